//--- eerd_engine.sv
/*
  Read engine of a two-wire serial EEPROM with APB register access.
  Assumes bus pins arrive asynchronous and are synchronised here, and
  that the write engine drives write_cycle_busy on this clock.
*/
// Functional notes
// (RULE_01) Reads begin start, type, address, read bit
// (RULE_02) Reads ignore protect pin and guard bit
// (RULE_03) Current read sends counter byte, then increments
// (RULE_04) Counter holds its value between operations
// (RULE_05) Array counter wraps last byte to first
// (RULE_06) Special accesses load the shared counter too; code loads it for identification page and serial word addresses only
// (RULE_07) Master should prefer random reads
// (RULE_08) Random read uses dummy write then restart
// (RULE_09) Read after dummy write uses preloaded address
// (RULE_10) Acked bytes continue; nack and stop end
// (RULE_11) Type 1011, bits 00 read identification page
// (RULE_12) Identification page read wraps within page
// (RULE_13) Lock query data acked only when unlocked
// (RULE_14) Start clears command state; stop idles
// (RULE_15) Type 1011, bits 11 read guard bit
// (RULE_16) Guard byte: seven zeros, guard in bit zero
// (RULE_17) Further guard bytes repeat the same value
// (RULE_18) Type 1011, bits 01 read serial block
// (RULE_19) Serial block is never modified
// (RULE_20) Serial block read wraps after sixteen bytes
// (RULE_21) Master reads serial from offset zero
// (RULE_22) Busy programming: address not acknowledged
// (RULE_23) Two address bits match straps; one is A8
`timescale 1ns/1ns
`default_nettype none
module eerd_engine
  import eerd_pkg::*;
#(
  parameter int unsigned ARRAY_SIZE = ARRAY_BYTES,
  parameter logic [127:0] SERIAL_VALUE = 128'h0123456789ABCDEF0F1E2D3C4B5A6978
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire eerd_apb_req_t apb_req,
  output var eerd_apb_rsp_t apb_rsp,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_drive_n,
  input wire logic write_protect_pin,
  input wire logic chip_select_strap_one,
  input wire logic chip_select_strap_two,
  input wire logic write_cycle_busy
);
  // SERIAL_VALUE default is arbitrary.
  if (ARRAY_SIZE != ARRAY_BYTES) begin : g_size_check
    $error("eerd_engine supports a 512-byte array only");
  end

  // ==========================================================
  // Storage
  logic [7:0] mem_array [ARRAY_BYTES];
  logic [7:0] identification_page [PAGE_BYTES];
  logic [7:0] serial_rom [PAGE_BYTES];

  for (genvar g = 0; g < PAGE_BYTES; g++) begin : g_serial
    assign serial_rom[g] = SERIAL_VALUE[127 - 8 * g -: 8]; // RULE_19
  end

  // ==========================================================
  // Pin synchronisers
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [2:0] pin_sync0;
  logic [2:0] pin_sync1;
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      pin_sync0 <= 3'h0;
      pin_sync1 <= 3'h0;
    end else if (clk_en) begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
      pin_sync0 <= {write_protect_pin, chip_select_strap_two,
                    chip_select_strap_one};
      pin_sync1 <= pin_sync0;
    end
  end

  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic strap_two_s;
  logic strap_one_s;
  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign {wp_s, strap_two_s, strap_one_s} = pin_sync1;

  logic ev_start;
  logic ev_stop;
  logic ev_rise;
  logic ev_fall;
  assign ev_start = clk_en & scl_s & scl_q & sda_q & ~sda_s; // RULE_01
  assign ev_stop = clk_en & scl_s & scl_q & ~sda_q & sda_s;
  assign ev_rise = clk_en & scl_s & ~scl_q;
  assign ev_fall = clk_en & ~scl_s & scl_q;

  // ==========================================================
  // Protocol state
  eerd_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic rw;
  logic special;
  logic dev_a8;
  logic [1:0] sp_mode;
  logic master_ack;
  logic [8:0] ctr;
  logic guard;
  logic locked;

  logic bit_done;
  logic addr_match;
  logic addr_ok;
  logic data_ack;
  logic load_byte;
  logic dev_decide;
  logic word_decide;
  logic data_decide;
  assign bit_done = bitcnt == BITS_PER_BYTE;
  assign addr_match = (shreg[7:4] == TYPE_ARRAY ||
                       shreg[7:4] == TYPE_SPECIAL) &&
                      shreg[3] == strap_two_s &&
                      shreg[2] == strap_one_s; // RULE_23
  assign addr_ok = addr_match & ~write_cycle_busy; // RULE_22
  assign dev_decide = ev_fall & ~ev_start & ~ev_stop &
                      state == ST_DEVADDR & bit_done;
  assign word_decide = ev_fall & ~ev_start & ~ev_stop &
                       state == ST_WORDADDR & bit_done;
  assign data_decide = ev_fall & ~ev_start & ~ev_stop &
                       state == ST_WRDATA & bit_done;
  assign data_ack = special ? (sp_mode == SP_IDPAGE & ~locked) // RULE_13
                            : ~(wp_s | guard);
  assign load_byte = ev_fall & ~ev_start & ~ev_stop &
                     ((state == ST_DEVACK & rw) |
                      (state == ST_RDACK & master_ack)); // RULE_10

  // Byte fetch and counter advance; protect state never blocks it
  logic [7:0] fetch;
  logic [8:0] next_ctr;
  always_comb begin
    fetch = mem_array[ctr]; // RULE_02 RULE_03 RULE_09
    next_ctr = ctr + 9'h001; // RULE_05
    if (special) begin
      next_ctr = {5'h00, ctr[3:0] + 4'h1}; // RULE_12 RULE_20
      unique case (sp_mode)
        SP_IDPAGE: fetch = identification_page[ctr[3:0]]; // RULE_11
        SP_SERIAL: fetch = serial_rom[ctr[3:0]]; // RULE_18
        SP_GUARD: begin
          fetch = {7'h00, guard}; // RULE_15 RULE_16
          next_ctr = ctr; // RULE_17
        end
        SP_LOCK: fetch = LOCK_READ_FILL;
      endcase
    end
  end

  // Shared address counter, untouched by reset-free idle periods
  always_ff @(posedge clk) begin
    if (reset) begin
      ctr <= 9'h000;
    end else if (dev_decide & addr_ok &
                 shreg[7:4] == TYPE_ARRAY) begin
      ctr[8] <= shreg[1]; // RULE_23
    end else if (word_decide) begin
      if (!special) begin
        ctr <= {dev_a8, shreg}; // RULE_09
      end else if (shreg[7:6] == SP_IDPAGE ||
                   shreg[7:6] == SP_SERIAL) begin
        ctr <= {5'h00, shreg[3:0]}; // RULE_06
      end
    end else if (load_byte) begin
      ctr <= next_ctr; // RULE_03 RULE_04
    end
  end

  // Serial bit engine
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      special <= 1'b0;
      dev_a8 <= 1'b0;
      sp_mode <= SP_IDPAGE;
      master_ack <= 1'b0;
      sda_drive_n <= 1'b1;
    end else if (ev_start) begin
      state <= ST_DEVADDR; // RULE_14
      bitcnt <= 4'h0;
      sda_drive_n <= 1'b1;
    end else if (ev_stop) begin
      state <= ST_IDLE; // RULE_14
      sda_drive_n <= 1'b1;
    end else if (clk_en) begin
      unique case (state)
        ST_IDLE: begin
          sda_drive_n <= 1'b1;
        end
        ST_DEVADDR, ST_WORDADDR, ST_WRDATA: begin
          if (ev_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (ev_fall && bit_done) begin
            if (state == ST_DEVADDR) begin
              if (addr_ok) begin
                sda_drive_n <= 1'b0; // RULE_01
                rw <= shreg[0];
                special <= shreg[7:4] == TYPE_SPECIAL;
                dev_a8 <= shreg[1];
                state <= ST_DEVACK;
              end else begin
                state <= ST_IDLE; // RULE_22
              end
            end else if (state == ST_WORDADDR) begin
              sda_drive_n <= 1'b0;
              if (special) begin
                sp_mode <= shreg[7:6];
              end
              state <= ST_WORDACK;
            end else if (data_ack) begin
              sda_drive_n <= 1'b0;
              state <= ST_WRACK;
            end else begin
              state <= ST_IDLE; // RULE_13
            end
          end
        end
        ST_DEVACK, ST_WORDACK, ST_WRACK: begin
          if (ev_fall) begin
            if (state == ST_DEVACK && rw) begin
              shreg <= fetch;
              sda_drive_n <= fetch[7];
              bitcnt <= 4'h1;
              state <= ST_RDDATA;
            end else begin
              sda_drive_n <= 1'b1;
              bitcnt <= 4'h0;
              state <= state == ST_DEVACK ? ST_WORDADDR : ST_WRDATA;
            end
          end
        end
        ST_RDDATA: begin
          if (ev_fall) begin
            if (bit_done) begin
              sda_drive_n <= 1'b1;
              state <= ST_RDACK;
            end else begin
              sda_drive_n <= shreg[6];
              shreg <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        ST_RDACK: begin
          if (ev_rise) begin
            master_ack <= ~sda_s;
          end else if (ev_fall) begin
            if (master_ack) begin
              shreg <= fetch; // RULE_10
              sda_drive_n <= fetch[7];
              bitcnt <= 4'h1;
              state <= ST_RDDATA;
            end else begin
              state <= ST_IDLE; // RULE_10
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          sda_drive_n <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sda_out <= 1'b0;
    end else if (clk_en) begin
      sda_out <= 1'b0;
    end
  end

  // ==========================================================
  // APB slave
  function automatic logic [3:0] reg_decode(input logic [11:0] a);
    reg_decode = {a == OFF_MEM_DATA, a == OFF_MEM_INDEX,
                  a == OFF_STATUS, a == OFF_CTRL};
  endfunction

  logic [9:0] mem_index;
  logic [3:0] rd_sel;
  logic [3:0] wr_sel;
  logic wr_fire;
  logic [7:0] mem_rd;
  logic [31:0] rd_data;
  assign rd_sel = reg_decode(apb_req.paddr);
  assign wr_sel = reg_decode(apb_req.paddr) & {4{wr_fire}};
  assign wr_fire = clk_en & apb_req.psel & apb_req.penable &
                   apb_req.pwrite & apb_rsp.pready;

  always_comb begin
    mem_rd = 8'h00;
    if (mem_index < MEM_ID_BASE) begin
      mem_rd = mem_array[mem_index[8:0]];
    end else if (mem_index < MEM_SERIAL_BASE) begin
      mem_rd = identification_page[mem_index[3:0]];
    end else if (mem_index < MEM_END) begin
      mem_rd = serial_rom[mem_index[3:0]];
    end
    rd_data = 32'h0000_0000;
    unique case (1'b1)
      rd_sel[0]: begin
        rd_data[CTRL_GUARD_POS] = guard;
        rd_data[CTRL_LOCK_POS] = locked;
      end
      rd_sel[1]: rd_data = {wp_s, 6'h00, state, 7'h00, ctr};
      rd_sel[2]: rd_data = {22'h000000, mem_index};
      rd_sel[3]: rd_data = {24'h000000, mem_rd};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      apb_rsp <= '0;
    end else if (clk_en) begin
      if (apb_req.psel && !apb_req.penable) begin
        apb_rsp.pready <= 1'b1;
        apb_rsp.pslverr <= ~|rd_sel;
        apb_rsp.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
      end else begin
        apb_rsp.pready <= 1'b0;
        apb_rsp.pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      guard <= 1'b0;
      locked <= 1'b0;
      mem_index <= 10'h000;
    end else begin
      if (wr_sel[0]) begin
        guard <= apb_req.pwdata[CTRL_GUARD_POS];
        locked <= apb_req.pwdata[CTRL_LOCK_POS];
      end
      if (wr_sel[2]) begin
        mem_index <= apb_req.pwdata[9:0];
      end
    end
  end

  // Content loading; the serial block has no write path
  always_ff @(posedge clk) begin
    if (wr_sel[3]) begin
      if (mem_index < MEM_ID_BASE) begin
        mem_array[mem_index[8:0]] <= apb_req.pwdata[7:0];
      end else if (mem_index < MEM_SERIAL_BASE) begin
        identification_page[mem_index[3:0]] <= apb_req.pwdata[7:0]; // RULE_19
      end
    end
  end

  // ==========================================================
  // Checks
  AST_ADDR_ACK: assert property (@(posedge clk) disable iff (reset) // RULE_01
    dev_decide && addr_ok |=> !sda_drive_n && state == ST_DEVACK)
    else $error("matching address not acknowledged");
  AST_BUSY_NACK: assert property (@(posedge clk) disable iff (reset) // RULE_22
    dev_decide && write_cycle_busy |=> state == ST_IDLE && sda_drive_n)
    else $error("address acknowledged while busy");
  AST_ARRAY_INCR: assert property (@(posedge clk) disable iff (reset) // RULE_03
    load_byte && !special |=> ctr == $past(ctr) + 9'h001 &&
      state == ST_RDDATA)
    else $error("array read did not advance counter");
  AST_ARRAY_WRAP: assert property (@(posedge clk) disable iff (reset) // RULE_05
    load_byte && !special && ctr == 9'h1FF |=> ctr == 9'h000)
    else $error("array counter did not wrap");
  AST_PAGE_WRAP: assert property (@(posedge clk) disable iff (reset) // RULE_12
    load_byte && special && sp_mode == SP_IDPAGE && ctr[3:0] == 4'hF
    |=> ctr == 9'h000)
    else $error("identification page did not wrap");
  AST_SERIAL_WRAP: assert property (@(posedge clk) disable iff (reset) // RULE_20
    load_byte && special && sp_mode == SP_SERIAL && ctr[3:0] == 4'hF
    |=> ctr == 9'h000 && shreg == serial_rom[15])
    else $error("serial block did not wrap");
  AST_GUARD_BYTE: assert property (@(posedge clk) disable iff (reset) // RULE_16
    load_byte && special && sp_mode == SP_GUARD
    |=> shreg == {7'h00, $past(guard)} && $stable(ctr))
    else $error("guard byte wrong");
  AST_LOCK_NACK: assert property (@(posedge clk) disable iff (reset) // RULE_13
    data_decide && special && sp_mode == SP_IDPAGE && locked
    |=> sda_drive_n && state == ST_IDLE)
    else $error("locked page query acknowledged");
  AST_START_CLEAR: assert property (@(posedge clk) disable iff (reset) // RULE_14
    ev_start |=> state == ST_DEVADDR && sda_drive_n && bitcnt == 4'h0)
    else $error("start did not clear command state");
  AST_NACK_END: assert property (@(posedge clk) disable iff (reset) // RULE_10
    ev_fall && !ev_start && !ev_stop && state == ST_RDACK && !master_ack
    |=> state == ST_IDLE ##1 sda_drive_n)
    else $error("read continued after master nack");
  AST_WORD_LOAD: assert property (@(posedge clk) disable iff (reset) // RULE_06
    word_decide && special && shreg[7:6] == SP_IDPAGE
    |=> ctr == {5'h00, $past(shreg[3:0])})
    else $error("special access did not load counter");
endmodule
`default_nettype wire

//--- eerd_master.sv
/*
  Two-wire bus master model: start, stop, byte out, byte in.
  Assumes an open-drain wire with a pull-up, clocked by the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module eerd_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // ==========================================================
  // Bit and frame tasks, 12 clocks per bus clock for each bit, 18 clocks for a start or a stop
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bit_out(input logic b);
    tick(4);
    sda_low <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(6);
    scl <= 1'b0;
  endtask
  task automatic bit_in(output logic b);
    tick(4);
    sda_low <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(3);
    b = sda;
    tick(3);
    scl <= 1'b0;
  endtask
  task automatic bus_start();
    tick(4);
    sda_low <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(6);
    sda_low <= 1'b1;
    tick(6);
    scl <= 1'b0;
  endtask
  task automatic bus_stop();
    tick(4);
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(6);
    sda_low <= 1'b0;
    tick(6);
  endtask
  task automatic put_byte(input logic [7:0] v, output logic a);
    logic b;
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    bit_in(b);
    a = ~b;
  endtask
  task automatic get_byte(input logic ack_it, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_in(v[i]);
    bit_out(~ack_it);
  endtask
endmodule
`default_nettype wire

//--- eerd_pkg.sv
/*
  Constants, states and bus carriers of the serial EEPROM read engine.
  Assumes a 32-bit APB master with 12 address bits reaching the block.
*/
`default_nettype none
package eerd_pkg;
  // ==========================================================
  // Memory spaces
  localparam int unsigned ARRAY_BYTES = 512;
  localparam int unsigned PAGE_BYTES = 16;
  localparam logic [3:0] TYPE_ARRAY = 4'hA;
  localparam logic [3:0] TYPE_SPECIAL = 4'hB;
  localparam logic [1:0] SP_IDPAGE = 2'h0;
  localparam logic [1:0] SP_SERIAL = 2'h1;
  localparam logic [1:0] SP_LOCK = 2'h2;
  localparam logic [1:0] SP_GUARD = 2'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] LOCK_READ_FILL = 8'hFF;
  // ==========================================================
  // Register map
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_MEM_INDEX = 12'h008;
  localparam logic [11:0] OFF_MEM_DATA = 12'h00C;
  localparam int unsigned CTRL_GUARD_POS = 0;
  localparam int unsigned CTRL_LOCK_POS = 1;
  localparam logic [9:0] MEM_ID_BASE = 10'h200;
  localparam logic [9:0] MEM_SERIAL_BASE = 10'h210;
  localparam logic [9:0] MEM_END = 10'h220;
  // ==========================================================
  // Types
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_DEVADDR = 9'h002,
    ST_DEVACK = 9'h004,
    ST_WORDADDR = 9'h008,
    ST_WORDACK = 9'h010,
    ST_WRDATA = 9'h020,
    ST_WRACK = 9'h040,
    ST_RDDATA = 9'h080,
    ST_RDACK = 9'h100
  } eerd_state_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } eerd_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } eerd_apb_rsp_t;
endpackage
`default_nettype wire

//--- tb_top.sv
/*
  Self-checking bench of the read engine.
  Assumes the package, engine and master model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import eerd_pkg::*;
  // Arbitrary serial block value
  localparam logic [127:0] SER = 128'h3C5A_9617_E2D4_0B88_7F21_C6A3_59E0_14BD;
  logic clk, reset, wp, busy, scl, sda, sda_low, sda_out, sda_drive_n;
  logic ack, err;
  logic [31:0] rd;
  logic [8:0] ra;
  logic [7:0] mem [0:527];
  logic [7:0] got [0:17];
  int errors, checks, seed;
  eerd_apb_req_t req;
  eerd_apb_rsp_t rsp;
  assign sda = ~(sda_low | ~sda_drive_n);
  eerd_engine #(.SERIAL_VALUE(SER)) dut (.clk(clk), .reset(reset),
    .clk_en(1'b1), .apb_req(req), .apb_rsp(rsp), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_drive_n(sda_drive_n),
    .write_protect_pin(wp), .chip_select_strap_one(1'b0),
    .chip_select_strap_two(1'b1), .write_cycle_busy(busy));
  eerd_master bfm (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  // ==========================================================
  // Helpers
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [7:0] ser_byte(input int i);
    return SER[8 * (15 - i) +: 8];
  endfunction
  task automatic close_out();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      errors++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      close_out();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic poke(input int i, input logic [7:0] v);
    apb(1'b1, OFF_MEM_INDEX, 32'(i));
    apb(1'b1, OFF_MEM_DATA, {24'h0, v});
  endtask
  task automatic dev(input logic [3:0] ty, input logic a8, input logic r);
    bfm.bus_start();
    bfm.put_byte({ty, 2'b10, a8, r}, ack);
  endtask
  task automatic rd_bytes(input logic [3:0] ty, input logic a8,
                          input logic rnd, input logic [7:0] wa, input int n);
    if (rnd) begin
      dev(ty, a8, 1'b0);
      chk(ack, 8'h01);
      bfm.put_byte(wa, ack);
      chk(ack, 8'h01);
    end
    dev(ty, a8, 1'b1);
    chk(ack, 8'h01);
    for (int i = 0; i < n; i++) bfm.get_byte(i < n - 1, got[i]);
    bfm.bus_stop();
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    close_out();
  end
  initial begin
    seed = 38;
    errors = 0;
    checks = 0;
    reset = 1'b1;
    wp = 1'b0;
    busy = 1'b0;
    req = '0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 528; i++) begin
      mem[i] = 8'($random(seed));
      poke(i, mem[i]);
    end
    apb(1'b0, OFF_MEM_DATA, 32'h0);
    chk(rd[7:0], mem[527]);
    chk(rd[15:8], 8'h00);
    apb(1'b0, 12'h010, 32'h0);
    chk({7'h0, err}, 8'h01);
    apb(1'b1, OFF_CTRL, 32'h1);
    wp <= 1'b1;
    rd_bytes(TYPE_ARRAY, 1'b1, 1'b1, 8'hFE, 4);
    for (int i = 0; i < 4; i++) chk(got[i], mem[(510 + i) % 512]);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({7'h0, rd[31]}, 8'h01);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd[7:0], 8'h01);
    rd_bytes(TYPE_ARRAY, 1'b0, 1'b0, 8'h00, 1);
    chk(got[0], mem[2]);
    rd_bytes(TYPE_SPECIAL, 1'b0, 1'b1, 8'h3E, 3);
    for (int i = 0; i < 3; i++) chk(got[i], mem[512 + (14 + i) % 16]);
    rd_bytes(TYPE_ARRAY, 1'b1, 1'b0, 8'h00, 1);
    chk(got[0], mem[257]);
    poke(528, 8'h00);
    dev(TYPE_SPECIAL, 1'b0, 1'b0);
    bfm.put_byte(8'h40, ack);
    bfm.put_byte(8'h00, ack);
    chk(ack, 8'h00);
    bfm.bus_stop();
    rd_bytes(TYPE_SPECIAL, 1'b0, 1'b1, 8'h70, 17);
    for (int i = 0; i < 17; i++) chk(got[i], ser_byte(i % 16));
    for (int g = 1; g >= 0; g--) begin
      apb(1'b1, OFF_CTRL, 32'(g));
      rd_bytes(TYPE_SPECIAL, 1'b0, 1'b1, 8'hC5, 2);
      chk(got[0], 8'(g));
      chk(got[1], 8'(g));
    end
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFF_CTRL, 32'(2 * k));
      dev(TYPE_SPECIAL, 1'b0, 1'b0);
      bfm.put_byte(8'h00, ack);
      bfm.put_byte(8'h5A, ack);
      chk(ack, 8'(1 - k));
      bfm.bus_start();
      bfm.bus_stop();
    end
    busy <= 1'b1;
    dev(TYPE_ARRAY, 1'b0, 1'b1);
    chk(ack, 8'h00);
    bfm.bus_stop();
    busy <= 1'b0;
    bfm.bus_start();
    bfm.put_byte({4'hA, 2'b01, 2'b01}, ack);
    chk(ack, 8'h00);
    dev(4'h9, 1'b0, 1'b1);
    chk(ack, 8'h00);
    bfm.bus_stop();
    repeat (4) begin
      ra = 9'($random(seed));
      rd_bytes(TYPE_ARRAY, ra[8], 1'b1, ra[7:0], 2);
      chk(got[0], mem[ra]);
      chk(got[1], mem[(ra + 1) % 512]);
    end
    chk({7'h0, sda_out}, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
